// *** core/adc_parallel_output_control.sv ***
/*
  Digital output side of a 10-bit pipelined converter: strap sampling,
  clock halving, recalibration control, latency pipeline and output format.
  Assumes the sample clock pair arrives as pins, the converter core result
  arrives on sys_clk as raw offset-binary code, and rst_b is the power-on reset.
*/
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Reference select low picks internal reference, high picks external.
// RQ2 - Clock halving input low divides sample clock by two; high passes it.
// RQ3 - Recalibration reset is active low; held low at power-up, outside may pull.
// RQ4 - Format select low gives two's complement output words.
// RQ5 - Each result is a 10-bit word, bit 0 least significant.
// RQ6 - Most significant bit leaves on bit 9.
// RQ7 - Output word appears 28 sample clocks after its conversion starts.
// RQ8 - Reset low one cycle requests recalibration; it starts on the rising edge.
// RQ9 - Over-range flag high from reset low until calibration completes.
// RQ10 - Forwarded clock held low during reset, resumes at next edge after release.
// RQ11 - Format select high gives offset binary, most negative input all zeros.
module adc_parallel_output_control
  import adc_out_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sample_clock_true,
  input wire logic sample_clock_comp,
  input wire logic reference_source_select,
  input wire logic clock_halve_n,
  input wire logic twos_comp_format_n,
  input wire logic recal_reset_in,
  input wire logic [SAMPLE_WIDTH-1:0] core_code,
  output logic recal_reset_out,
  output logic recal_reset_oe,
  output logic use_external_ref,
  output logic [SAMPLE_WIDTH-1:0] sample_word,
  output logic sample_bit_lsb,
  output logic sample_bit_msb,
  output logic forwarded_sample_clock,
  output logic over_range,
  output logic cal_busy
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] sample_clock_true_sync;
    logic [1:0] sample_clock_comp_sync;
    logic [1:0] rst_sync;
    logic [1:0] ref_sync;
    logic [1:0] halve_sync;
    logic [1:0] fmt_sync;
    logic clk_prev;
    logic rst_prev;
    logic half_phase;
    cal_state_t state;
    logic [CAL_CNT_WIDTH-1:0] cal_cnt;
    logic [PIPE_LATENCY-1:0][SAMPLE_WIDTH:0] pipe;
    logic fwd_clk;
    logic wire_low;
    logic drive_n;
    logic use_ext;
    logic [SAMPLE_WIDTH-1:0] word;
    logic ovr;
    logic busy;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic clk_diff;
  logic clk_rise;
  logic sample_tick;
  logic reset_low;
  logic rst_fell;
  logic raw_over;
  logic [SAMPLE_WIDTH-1:0] fmt_word;

  function automatic logic [SAMPLE_WIDTH-1:0] format_code(input logic [SAMPLE_WIDTH-1:0] code,
                                                         input logic fmt_n);
    format_code = fmt_n ? code : (code ^ MSB_FLIP); // RQ4 RQ11
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Every pin passes two flops before any decision reads it
    s_next.sample_clock_true_sync = {s_reg.sample_clock_true_sync[0], sample_clock_true};
    s_next.sample_clock_comp_sync = {s_reg.sample_clock_comp_sync[0], sample_clock_comp};
    s_next.rst_sync = {s_reg.rst_sync[0], recal_reset_in};
    s_next.ref_sync = {s_reg.ref_sync[0], reference_source_select};
    s_next.halve_sync = {s_reg.halve_sync[0], clock_halve_n};
    s_next.fmt_sync = {s_reg.fmt_sync[0], twos_comp_format_n};

    // ****************************************
    // Sample clock edge and halving
    // ****************************************
    // Differential decision taken only from settled stage
    clk_diff = s_reg.sample_clock_true_sync[1] & ~s_reg.sample_clock_comp_sync[1];
    clk_rise = clk_diff & ~s_reg.clk_prev;
    s_next.clk_prev = clk_diff;
    // Halving uses rising edges only, so when halved the forwarded clock is high a quarter of its period
    sample_tick = 1'b0;
    if (clk_rise) begin
      if (s_reg.halve_sync[1]) begin
        sample_tick = 1'b1; // RQ2
      end else begin
        s_next.half_phase = ~s_reg.half_phase;
        sample_tick = s_reg.half_phase; // RQ2
      end
    end

    // ****************************************
    // Straps
    // ****************************************
    s_next.use_ext = (s_reg.ref_sync[1] == REF_EXTERNAL); // RQ1

    // ****************************************
    // Calibration control
    // ****************************************
    // Falling edge of the settled wire; the self-held low at power-up
    // leaves the previous value low, so leaving it gives no false request
    rst_fell = s_reg.rst_prev & ~s_reg.rst_sync[1];
    reset_low = ~s_reg.rst_sync[1] | (s_reg.state == ST_HELD);
    s_next.rst_prev = s_reg.rst_sync[1];
    raw_over = s_reg.pipe[PIPE_LATENCY-1][SAMPLE_WIDTH];
    fmt_word = format_code(s_reg.pipe[PIPE_LATENCY-1][SAMPLE_WIDTH-1:0], s_reg.fmt_sync[1]);
    unique case (s_reg.state)
      ST_HELD: begin
        // Power-up: device drives reset low itself until calibrated
        if (s_reg.cal_cnt >= CAL_CNT_WIDTH'(CAL_CYCLES)) begin
          s_next.state = ST_RUN; // RQ3
          s_next.cal_cnt = '0;
        end else begin
          s_next.cal_cnt = s_reg.cal_cnt + CAL_ONE;
        end
      end
      ST_CAL: begin
        if (~s_reg.rst_sync[1]) begin
          s_next.cal_cnt = '0;
        end else if (s_reg.cal_cnt >= CAL_CNT_WIDTH'(CAL_CYCLES)) begin
          s_next.state = ST_RUN; // RQ9
          s_next.cal_cnt = '0;
        end else if (s_reg.rst_prev | (s_reg.cal_cnt != '0)) begin
          s_next.cal_cnt = s_reg.cal_cnt + CAL_ONE; // RQ8
        end
      end
      ST_RUN: begin
        // Limitation: a wire still held low by the outside when the
        // power-up calibration ends is only seen at its next fall
        if (rst_fell) begin
          s_next.state = ST_CAL; // RQ8
          s_next.cal_cnt = '0;
        end
      end
      default: begin
        // Unused code: restart calibration from the beginning
        s_next.state = ST_HELD;
        s_next.cal_cnt = '0;
      end
    endcase
    // Open-drain wire: data always low, enable low only while self-held
    s_next.wire_low = 1'b0;
    s_next.drive_n = (s_next.state != ST_HELD); // RQ3

    // ****************************************
    // Sample pipeline and format
    // ****************************************
    // Sample pipeline: one stage per sample tick
    if (sample_tick) begin
      s_next.pipe[0] = {(core_code == CODE_MAX) | (core_code == CODE_MIN), core_code};
      for (int i = 1; i < PIPE_LATENCY; i++) begin
        s_next.pipe[i] = s_reg.pipe[i-1]; // RQ7
      end
      s_next.word = fmt_word; // RQ5 RQ6
    end
    s_next.busy = (s_next.state != ST_RUN);

    // ****************************************
    // Forwarded clock and over-range
    // ****************************************
    // Forwarded clock follows sample ticks, stopped low during reset
    if (reset_low) begin
      s_next.fwd_clk = 1'b0; // RQ10
    end else if (clk_rise) begin
      s_next.fwd_clk = sample_tick ? 1'b1 : s_reg.fwd_clk; // RQ10
    end else if (~clk_diff) begin
      s_next.fwd_clk = 1'b0;
    end
    s_next.ovr = (s_next.state != ST_RUN) ? 1'b1 : raw_over; // RQ9
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.state <= ST_HELD;
      s_reg.ovr <= 1'b1;
      s_reg.busy <= 1'b1;
      s_reg.rst_sync <= 2'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open-drain reset: enable low means driving low, only while self-held
  // Both come from flops so the pin never sees a decode glitch
  assign recal_reset_out = s_reg.wire_low;
  assign recal_reset_oe = s_reg.drive_n; // RQ3
  assign use_external_ref = s_reg.use_ext;
  assign sample_word = s_reg.word;
  assign sample_bit_lsb = s_reg.word[LSB_POS];
  assign sample_bit_msb = s_reg.word[MSB_POS];
  assign forwarded_sample_clock = s_reg.fwd_clk;
  assign over_range = s_reg.ovr;
  assign cal_busy = s_reg.busy;

endmodule // adc_parallel_output_control

// *** core/adc_out_pkg.sv ***
/*
  Constants for the converter output control block: widths, pipeline
  latency, calibration length and encodings.
  Assumes a single 100 MHz system clock; no bus.
*/
package adc_out_pkg;
  localparam int SAMPLE_WIDTH = 10;
  localparam int MSB_POS = 9;
  localparam int LSB_POS = 0;
  localparam int PIPE_LATENCY = 28;
  localparam int CAL_CYCLES_DEFAULT = 1000;
  localparam int CAL_CNT_WIDTH = 24;
  localparam logic REF_INTERNAL = 1'b0;
  localparam logic REF_EXTERNAL = 1'b1;
  localparam logic [SAMPLE_WIDTH-1:0] MSB_FLIP = 10'h200;
  localparam logic [SAMPLE_WIDTH-1:0] CODE_MAX = 10'h3FF;
  localparam logic [SAMPLE_WIDTH-1:0] CODE_MIN = 10'h000;
  localparam logic [CAL_CNT_WIDTH-1:0] CAL_ONE = 24'h000001;
  typedef enum logic [1:0] {
    ST_HELD,
    ST_CAL,
    ST_RUN
  } cal_state_t;
endpackage

// *** verif/adc_out_monitor.sv ***
/* Checker on the output control ports.
   Assumes one clock domain and CAL_CYCLES handed on by the bind. */
`timescale 1ns/1ps
module adc_out_monitor
  import adc_out_pkg::*;
#(parameter int CAL_CYCLES = 8) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reference_source_select,
  input wire logic recal_reset_in,
  input wire logic recal_reset_oe,
  input wire logic use_external_ref,
  input wire logic [SAMPLE_WIDTH-1:0] sample_word,
  input wire logic sample_bit_lsb,
  input wire logic sample_bit_msb,
  input wire logic forwarded_sample_clock,
  input wire logic over_range,
  input wire logic cal_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Sync adds two cycles before the count starts
  sequence s_cal_run;
    ##CAL_CYCLES cal_busy ##[1:4] !cal_busy;
  endsequence
  a_ref_ext: assert property (reference_source_select [*4] |-> use_external_ref) else $error("ref ext");
  a_ref_int: assert property (!reference_source_select [*4] |-> !use_external_ref) else $error("ref int");
  a_oe_power: assert property ($rose(rst_b) |-> !recal_reset_oe [*8]) else $error("oe power");
  a_oe_free: assert property (!cal_busy |-> recal_reset_oe) else $error("oe run");
  a_recal_go: assert property ($fell(recal_reset_in) && recal_reset_oe |-> ##[1:3] cal_busy) else $error("go");
  a_cal_end: assert property ($rose(recal_reset_in) && cal_busy && recal_reset_oe |-> s_cal_run) else $error("end");
  a_cal_quiet: assert property (cal_busy |-> over_range) else $error("quiet");
  a_clk_stop: assert property (!recal_reset_in [*4] |-> !forwarded_sample_clock) else $error("clock stop");
  a_word_stand: assert property ($changed(sample_word) && !cal_busy |-> $rose(forwarded_sample_clock))
    else $error("word stand");
  a_bit_copy: assert property (##1 {sample_bit_msb, sample_bit_lsb} == {sample_word[MSB_POS], sample_word[LSB_POS]})
    else $error("bits");
endmodule // adc_out_monitor
bind adc_parallel_output_control adc_out_monitor #(.CAL_CYCLES(CAL_CYCLES)) i_mon (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .reference_source_select(reference_source_select),
  .recal_reset_in(recal_reset_in),
  .recal_reset_oe(recal_reset_oe),
  .use_external_ref(use_external_ref),
  .sample_word(sample_word),
  .sample_bit_lsb(sample_bit_lsb),
  .sample_bit_msb(sample_bit_msb),
  .forwarded_sample_clock(forwarded_sample_clock),
  .over_range(over_range),
  .cal_busy(cal_busy)
);

// *** verif/adc_capture_model.sv ***
/* Capture logic at the far side of the output port.
   Samples on sys_clk, so word and clock may change together. */
`timescale 1ns/1ps
module adc_capture_model
  import adc_out_pkg::*;
(
  input wire logic sys_clk,
  input wire logic forwarded_sample_clock,
  input wire logic [SAMPLE_WIDTH-1:0] sample_word,
  output logic [SAMPLE_WIDTH-1:0] word_cap,
  output int n_rise = 0
);
  logic fwd_q = 1'b0;
  always @(posedge sys_clk) begin
    fwd_q <= forwarded_sample_clock;
    if (forwarded_sample_clock && !fwd_q) begin
      word_cap <= sample_word;
      n_rise <= n_rise + 1;
    end
  end
endmodule // adc_capture_model

// *** verif/test_adc_parallel_output_control.sv ***
/* Bench with capture model; sample clock runs at sys_clk / 8.
   Drives straps, core code and the open-drain recal wire. */
`timescale 1ns/1ps
module test_adc_parallel_output_control;
  import adc_out_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, sample_clock_true = 1'b0, reference_source_select = 1'b0;
  logic clock_halve_n = 1'b1, twos_comp_format_n = 1'b0, drv = 1'b1;
  logic [SAMPLE_WIDTH-1:0] core_code = 10'h000, sample_word, word_cap;
  logic recal_reset_out, recal_reset_oe, use_external_ref, sample_bit_lsb, sample_bit_msb;
  logic forwarded_sample_clock, over_range, cal_busy;
  logic [2:0] sc = 3'h0;
  int fails = 0, n_tests = 0, n_rise;
  wire sample_clock_comp = ~sample_clock_true;
  wire recal_reset_in = drv & (recal_reset_oe | recal_reset_out);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    sc <= sc + 3'h1;
    sample_clock_true <= sc[2];
  end
  adc_parallel_output_control #(.CAL_CYCLES(8)) i_dut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sample_clock_true(sample_clock_true),
    .sample_clock_comp(sample_clock_comp),
    .reference_source_select(reference_source_select),
    .clock_halve_n(clock_halve_n),
    .twos_comp_format_n(twos_comp_format_n),
    .recal_reset_in(recal_reset_in),
    .core_code(core_code),
    .recal_reset_out(recal_reset_out),
    .recal_reset_oe(recal_reset_oe),
    .use_external_ref(use_external_ref),
    .sample_word(sample_word),
    .sample_bit_lsb(sample_bit_lsb),
    .sample_bit_msb(sample_bit_msb),
    .forwarded_sample_clock(forwarded_sample_clock),
    .over_range(over_range),
    .cal_busy(cal_busy)
  );
  adc_capture_model i_cap (
    .sys_clk(sys_clk),
    .forwarded_sample_clock(forwarded_sample_clock),
    .sample_word(sample_word),
    .word_cap(word_cap),
    .n_rise(n_rise)
  );
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 100 && cal_busy !== 1'b0; i++) @(negedge sys_clk);
    chk("idle", cal_busy, 1'b0);
    if (cal_busy !== 1'b0) end_of_test();
  endtask
  task automatic t_ref;
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk) reference_source_select <= v[0];
      repeat (5) @(negedge sys_clk);
      chk("ext_ref", use_external_ref, v[0]);
    end
    $display("done ref");
  endtask
  task automatic t_halve;
    int n0;
    for (int h = 0; h < 2; h++) begin
      @(posedge sys_clk) clock_halve_n <= h[0];
      repeat (40) @(negedge sys_clk);
      n0 = n_rise;
      repeat (128) @(negedge sys_clk);
      chk("rises", 16'(n_rise - n0), h ? 16'h0010 : 16'h0008);
    end
    $display("done halve");
  endtask
  task automatic t_fmt;
    int n0;
    for (int f = 0; f < 2; f++) begin
      @(posedge sys_clk) twos_comp_format_n <= f[0];
      // Change just after a fall so the next rise sees it settled
      @(negedge sample_clock_true);
      @(posedge sys_clk) core_code <= 10'h1C3;
      @(negedge sys_clk);
      n0 = n_rise;
      for (int i = 0; i < 400 && word_cap !== (f ? 10'h1C3 : 10'h3C3); i++) @(negedge sys_clk);
      chk("word", word_cap, f ? 10'h1C3 : 10'h3C3);
      chk("msb", sample_bit_msb, f ? 1'b0 : 1'b1);
      chk("lsb", sample_bit_lsb, 1'b1);
      chk("latency", 16'(n_rise - n0), 16'(PIPE_LATENCY + 1));
      @(posedge sys_clk) core_code <= 10'h155;
      repeat (300) @(posedge sys_clk);
    end
    $display("done format");
  endtask
  task automatic t_recal;
    @(posedge sys_clk) drv <= 1'b0;
    repeat (3) @(posedge sys_clk);
    drv <= 1'b1;
    @(negedge sys_clk);
    chk("cal", {cal_busy, over_range, forwarded_sample_clock}, 3'b110);
    wait_idle();
    @(negedge sys_clk);
    chk("range", over_range, 1'b0);
    $display("done recal");
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_idle();
    t_ref();
    t_halve();
    t_fmt();
    t_recal();
    end_of_test();
  end
endmodule // test_adc_parallel_output_control
